// >>> ssr_pkg.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: constants for the two-wire serial bus status reporter
// Assumes: 10 MHz system clock, word-addressed Avalon-MM register port
// Notes:   status codes are multiples of eight; only bits 7..3 are stored
//////////////////////////////////////////////////////////////////////////////
package ssr_pkg;

  // register byte offsets
  localparam logic [4:0] OFF_CTRL   = 5'h00;
  localparam logic [4:0] OFF_DATA   = 5'h04;
  localparam logic [4:0] OFF_ADDR   = 5'h08;
  localparam logic [4:0] OFF_STATUS = 5'h0c;
  localparam logic [4:0] OFF_RATE   = 5'h10;

  // control register bit positions
  localparam int CTL_ACK   = 0;
  localparam int CTL_STOP  = 1;
  localparam int CTL_START = 2;
  localparam int CTL_SI    = 3;
  localparam int CTL_BUSY  = 4;
  localparam int CTL_MAST  = 5;
  localparam int CTL_EN    = 6;

  // reset values
  localparam logic [7:0] RATE_RST = 8'h00;
  localparam logic [6:0] OWN_RST  = 7'h00;

  // timing: half bit period and clock-high limit, per clock-rate step
  localparam int HALF_MULT = 4;
  localparam int TO_MULT   = 32;

  // status codes
  localparam logic [7:0] C_START  = 8'h08;
  localparam logic [7:0] C_RSTART = 8'h10;
  localparam logic [7:0] C_AW_ACK = 8'h18;
  localparam logic [7:0] C_AW_NAK = 8'h20;
  localparam logic [7:0] C_TX_ACK = 8'h28;
  localparam logic [7:0] C_TX_NAK = 8'h30;
  localparam logic [7:0] C_ARB    = 8'h38;
  localparam logic [7:0] C_AR_ACK = 8'h40;
  localparam logic [7:0] C_AR_NAK = 8'h48;
  localparam logic [7:0] C_RX_ACK = 8'h50;
  localparam logic [7:0] C_RX_NAK = 8'h58;
  localparam logic [7:0] C_SW     = 8'h60;
  localparam logic [7:0] C_SW_ARB = 8'h68;
  localparam logic [7:0] C_GC     = 8'h70;
  localparam logic [7:0] C_GC_ARB = 8'h78;
  localparam logic [7:0] C_SR_ACK = 8'h80;
  localparam logic [7:0] C_SR_NAK = 8'h88;
  localparam logic [7:0] C_GR_ACK = 8'h90;
  localparam logic [7:0] C_GR_NAK = 8'h98;
  localparam logic [7:0] C_SSTOP  = 8'ha0;
  localparam logic [7:0] C_SR     = 8'ha8;
  localparam logic [7:0] C_SR_ARB = 8'hb0;
  localparam logic [7:0] C_ST_ACK = 8'hb8;
  localparam logic [7:0] C_ST_NAK = 8'hc0;
  localparam logic [7:0] C_ST_END = 8'hc8;
  localparam logic [7:0] C_TOUT   = 8'hd0;
  localparam logic [7:0] C_BERR   = 8'h00;
  localparam logic [7:0] C_IDLE   = 8'hf8;

  typedef enum logic [3:0] {
    SSR_IDLE, SSR_START, SSR_WAIT, SSR_XFER, SSR_LISTEN,
    SSR_RS_A, SSR_RS_B, SSR_STOP_A, SSR_STOP_B
  } ssr_state_e;

endpackage

// >>> ssr_smbus.sv
//////////////////////////////////////////////////////////////////////////////
// Purpose: two-wire serial bus master/slave with status-code reporting
// Assumes: open-drain pins, oe high pulls the line low; Avalon-MM slave
// Notes:   all state freezes while clk_en_in is low
//////////////////////////////////////////////////////////////////////////////
// What this block does
// - report 0x08 after start, 0x10 repeated
// - address+write: 0x18 acked, 0x20 not
// - master data sent: 0x28 acked, 0x30 not
// - arbitration lost 0x38, own write address 0x68
// - address+read: 0x40 acked, 0x48 not
// - master receive: 0x50 acked, 0x58 not
// - cleared ack bit gives no-ack next byte
// - ack own write address, report 0x60
// - general call 0x70, after lost arbitration 0x78
// - slave receive: 0x80 acked, 0x88 not
// - general call bytes: 0x90 acked, 0x98 not
// - addressed slave sees stop/restart: report 0xa0
// - ack own read address, report 0xa8
// - lost arbitration then own read: 0xb0
// - slave transmit: 0xb8 acked, 0xc0 not, then back to listening
// - final byte still acked: report 0xc8
// - clock high too long: report 0xd0
// - illegal start or stop: report 0x00
// - idle holds 0xf8 without raising flag
// - code in bits 7..3, low bits zero
// - general call only when enabled
//////////////////////////////////////////////////////////////////////////////
`timescale 1ns/10ps
module ssr_smbus
  import ssr_pkg::*;
(
  // clock, reset, enable
  input  wire logic        clk_sys_in,
  input  wire logic        sys_rst_in,
  input  wire logic        clk_en_in,
  // avalon-mm register port
  input  wire logic [2:0]  avs_address_in,
  input  wire logic        avs_read_in,
  input  wire logic        avs_write_in,
  input  wire logic [31:0] avs_writedata_in,
  input  wire logic [3:0]  avs_byteenable_in,
  output logic      [31:0] avs_readdata_out,
  output logic             avs_waitrequest_out,
  // serial bus pins
  input  wire logic        scl_in,
  output logic             scl_out,
  output logic             scl_oe_out,
  input  wire logic        sda_in,
  output logic             sda_out,
  output logic             sda_oe_out,
  // serial interrupt flag level
  output logic             si_out
);

  function automatic logic reg_sel(input logic [2:0] a, input logic [4:0] off);
    reg_sel = (a == off[4:2]);
  endfunction

  function automatic logic [4:0] cd(input logic [7:0] c);
    cd = c[7:3];
  endfunction

  //////////////////////////////////////////////////////////////////////////////
  // pin synchronisers and bus condition detection
  logic scl_m, scl_s, scl_p, sda_m, sda_s, sda_p;

  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      {scl_m, scl_s, scl_p} <= 3'h7;
      {sda_m, sda_s, sda_p} <= 3'h7;
    end else if (clk_en_in) begin
      {scl_m, scl_s, scl_p} <= {scl_in, scl_m, scl_s};
      {sda_m, sda_s, sda_p} <= {sda_in, sda_m, sda_s};
    end
  end

  wire scl_rise  = scl_s & ~scl_p;
  wire scl_fall  = ~scl_s & scl_p;
  wire start_det = scl_s & scl_p & sda_p & ~sda_s;
  wire stop_det  = scl_s & scl_p & ~sda_p & sda_s;

  //////////////////////////////////////////////////////////////////////////////
  // state
  ssr_state_e  st;
  logic [7:0]  data_q, shift, rate_q;
  logic [6:0]  own_addr;
  logic [4:0]  code;
  logic [3:0]  bitcnt;
  logic [10:0] tmr;
  logic [13:0] to_cnt;
  logic        ack_assert, stop_req, start_req, enable, gc_en;
  logic        is_master, addressed, gc_mode, arb_lost, role_tx, kind_addr;
  logic        rw, ack_seen, skip, phase_hi, last_tx, err, rep, bus_busy;

  //////////////////////////////////////////////////////////////////////////////
  // register decode
  wire        wr_go   = avs_write_in & ~avs_waitrequest_out & avs_byteenable_in[0];
  wire [7:0]  wd      = avs_writedata_in[7:0];
  wire        wr_ctl  = wr_go & reg_sel(avs_address_in, OFF_CTRL);
  wire        wr_data = wr_go & reg_sel(avs_address_in, OFF_DATA);
  wire        wr_addr = wr_go & reg_sel(avs_address_in, OFF_ADDR);
  wire        wr_rate = wr_go & reg_sel(avs_address_in, OFF_RATE);
  wire        si_clr  = wr_ctl & ~wd[CTL_SI] & si_out;
  wire [7:0]  ctl_rd  = {1'b0, enable, is_master, bus_busy, si_out,
                         start_req, stop_req, ack_assert};
  // status is read-only; a write there is simply dropped
  wire [7:0]  rd_byte =
    reg_sel(avs_address_in, OFF_CTRL)   ? ctl_rd :
    reg_sel(avs_address_in, OFF_DATA)   ? data_q :
    reg_sel(avs_address_in, OFF_ADDR)   ? {own_addr, gc_en} :
    reg_sel(avs_address_in, OFF_STATUS) ? {code, 3'h0} :
    reg_sel(avs_address_in, OFF_RATE)   ? rate_q : 8'h00;

  // one wait cycle on every access, so read data is always from a flop
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      avs_waitrequest_out <= 1'b1;
      avs_readdata_out    <= 32'h0;
    end else if (clk_en_in) begin
      avs_waitrequest_out <= ~((avs_read_in | avs_write_in) & avs_waitrequest_out);
      if (avs_read_in & avs_waitrequest_out)
        avs_readdata_out <= {24'h0, rd_byte};
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // timing and address matching
  wire [8:0]  rate_p1  = {1'b0, rate_q} + 9'd1;
  wire [10:0] half_cyc = 11'(rate_p1 * HALF_MULT);
  wire [13:0] to_lim   = 14'(rate_p1 * TO_MULT);
  wire        tmr_hit  = (tmr == half_cyc);
  wire        to_hit   = (to_cnt == to_lim);
  wire        own_hit  = (shift[7:1] == own_addr);
  wire        gc_hit   = gc_en & (shift == 8'h00);
  wire        cond     = start_det | stop_det;
  wire        xf_ev    = clk_en_in & (st == SSR_XFER) & ~to_hit;
  wire        a0_ev    = xf_ev & cond & addressed & (bitcnt == 4'd0) & ~skip;
  wire        berr_ev  = xf_ev & cond & ~a0_ev;
  wire        fall_ok  = xf_ev & ~cond & scl_fall & ~skip;
  wire        ack_slot = fall_ok & (bitcnt == 4'd7);
  wire        byte_end = fall_ok & (bitcnt == 4'd8);
  wire        gave_ack = sda_oe_out;

  // code for the byte that just finished, chosen by role and acknowledge
  wire [7:0] done_code =
    (is_master &  kind_addr &  rw) ? (ack_seen ? C_AR_ACK : C_AR_NAK) :
    (is_master &  kind_addr & ~rw) ? (ack_seen ? C_AW_ACK : C_AW_NAK) :
    (is_master &  role_tx)         ? (ack_seen ? C_TX_ACK : C_TX_NAK) :
    (is_master)                    ? (gave_ack ? C_RX_ACK : C_RX_NAK) :
    (kind_addr &  rw)              ? (arb_lost ? C_SR_ARB : C_SR)     :
    (kind_addr &  gc_mode)         ? (arb_lost ? C_GC_ARB : C_GC)     :
    (kind_addr)                    ? (arb_lost ? C_SW_ARB : C_SW)     :
    (role_tx & ~ack_seen)          ? C_ST_NAK :
    (role_tx &  last_tx)           ? C_ST_END :
    (role_tx)                      ? C_ST_ACK :
    (gc_mode)                      ? (gave_ack ? C_GR_ACK : C_GR_NAK) :
                                     (gave_ack ? C_SR_ACK : C_SR_NAK);

  //////////////////////////////////////////////////////////////////////////////
  // open-drain data levels are constant low; only the enables move
  always_ff @(posedge clk_sys_in) begin
    scl_out <= 1'b0;
    sda_out <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // protocol engine
  always_ff @(posedge clk_sys_in) begin
    if (sys_rst_in) begin
      st <= SSR_IDLE;
      {data_q, shift} <= 16'h0;
      rate_q <= RATE_RST;
      own_addr <= OWN_RST;
      code <= cd(C_IDLE);
      bitcnt <= 4'h0;
      tmr <= 11'h0;
      to_cnt <= 14'h0;
      {ack_assert, stop_req, start_req, enable, gc_en} <= 5'h0;
      {is_master, addressed, gc_mode, arb_lost, role_tx, kind_addr} <= 6'h0;
      {rw, ack_seen, skip, phase_hi, last_tx, err, rep, bus_busy} <= 8'h0;
      {si_out, scl_oe_out, sda_oe_out} <= 3'h0;
    end else if (clk_en_in) begin
      // software side; hardware assignments further down win
      if (wr_ctl) begin
        ack_assert <= wd[CTL_ACK];
        stop_req   <= wd[CTL_STOP];
        start_req  <= wd[CTL_START];
        enable     <= wd[CTL_EN];
        if (!wd[CTL_SI])
          si_out <= 1'b0;
      end
      if (wr_data)
        data_q <= wd;
      if (wr_addr) begin
        own_addr <= wd[7:1];
        gc_en    <= wd[0];
      end
      if (wr_rate)
        rate_q <= wd;
      if (start_det)
        bus_busy <= 1'b1;
      else if (stop_det)
        bus_busy <= 1'b0;
      to_cnt <= (bus_busy & scl_s & ~err & ~to_hit) ? to_cnt + 14'd1 : 14'h0;

      case (st)
        SSR_IDLE: begin
          {sda_oe_out, scl_oe_out, is_master, addressed, err} <= 5'h0;
          if (!si_out)
            code <= cd(C_IDLE);
          if (stop_req)
            stop_req <= 1'b0;
          else if (enable && start_det) begin
            st <= SSR_XFER;
            {bitcnt, skip, kind_addr, role_tx, arb_lost} <= {4'h0, 4'b1100};
          end else if (enable && start_req && !bus_busy) begin
            st <= SSR_START;
            {sda_oe_out, is_master, rep} <= 3'b110;
            tmr <= 11'h0;
          end
        end
        SSR_START: begin
          tmr <= tmr + 11'd1;
          if (tmr_hit) begin
            scl_oe_out <= 1'b1;
            code <= rep ? cd(C_RSTART) : cd(C_START);
            si_out <= 1'b1;
            {role_tx, kind_addr} <= 2'b11;
            st <= SSR_WAIT;
          end
        end
        SSR_WAIT: begin
          if (si_clr) begin
            // act on the request bits of the same write that clears the flag
            if (wd[CTL_STOP]) begin
              if (is_master) begin
                st <= SSR_STOP_A;
                sda_oe_out <= 1'b1;
                tmr <= 11'h0;
              end else begin
                st <= SSR_IDLE;
                {stop_req, scl_oe_out, sda_oe_out, err} <= 4'h0;
              end
            end else if (err) begin
              st <= SSR_WAIT; // only a stop request leaves an error
            end else if (wd[CTL_START] && is_master) begin
              st <= SSR_RS_A;
              sda_oe_out <= 1'b0;
              tmr <= 11'h0;
            end else begin
              st <= SSR_XFER;
              {bitcnt, phase_hi, skip} <= 6'h0;
              tmr <= 11'h0;
              if (role_tx) begin
                shift <= data_q;
                sda_oe_out <= ~data_q[7];
                last_tx <= ~wd[CTL_ACK];
                if (kind_addr)
                  rw <= data_q[0];
              end else
                sda_oe_out <= 1'b0;
              if (!is_master)
                scl_oe_out <= 1'b0;
            end
          end
        end
        SSR_RS_A: begin
          tmr <= tmr + 11'd1;
          if (tmr_hit) begin
            scl_oe_out <= 1'b0;
            tmr <= 11'h0;
            st <= SSR_RS_B;
          end
        end
        SSR_RS_B: begin
          if (scl_s)
            tmr <= tmr + 11'd1;
          if (tmr_hit) begin
            {sda_oe_out, rep} <= 2'b11;
            tmr <= 11'h0;
            st <= SSR_START;
          end
        end
        SSR_STOP_A: begin
          tmr <= tmr + 11'd1;
          if (tmr_hit) begin
            scl_oe_out <= 1'b0;
            tmr <= 11'h0;
            st <= SSR_STOP_B;
          end
        end
        SSR_STOP_B: begin
          if (scl_s)
            tmr <= tmr + 11'd1;
          if (tmr_hit) begin
            {sda_oe_out, stop_req} <= 2'b00;
            st <= SSR_IDLE;
          end
        end
        SSR_LISTEN: begin
          {sda_oe_out, scl_oe_out, addressed} <= 3'h0;
          if (stop_det)
            st <= SSR_IDLE;
          else if (start_det) begin
            st <= SSR_XFER;
            {bitcnt, skip, kind_addr, role_tx, arb_lost} <= {4'h0, 4'b1100};
          end
        end
        SSR_XFER: begin
          // master clock: low half, release, wait for the line, high half
          if (is_master) begin
            if (!phase_hi) begin
              tmr <= tmr + 11'd1;
              if (tmr_hit) begin
                {scl_oe_out, phase_hi} <= 2'b01;
                tmr <= 11'h0;
              end
            end else if (scl_s) begin
              tmr <= tmr + 11'd1;
              if (tmr_hit) begin
                {scl_oe_out, phase_hi} <= 2'b10;
                tmr <= 11'h0;
              end
            end
          end
          if (a0_ev) begin
            code <= cd(C_SSTOP);
            si_out <= 1'b1;
            addressed <= 1'b0;
            st <= stop_det ? SSR_IDLE : SSR_XFER;
            {bitcnt, skip, kind_addr, role_tx, arb_lost} <= {4'h0, 4'b1100};
          end else if (cond) begin
            code <= cd(C_BERR);
            {si_out, err} <= 2'b11;
            {sda_oe_out, scl_oe_out, is_master, addressed} <= 4'h0;
            st <= SSR_WAIT;
          end else if (scl_rise) begin
            if (bitcnt != 4'd8) begin
              shift <= {shift[6:0], sda_s};
              if (is_master && role_tx && !sda_oe_out && !sda_s) begin
                // another master pulled a released bit low
                {is_master, role_tx, scl_oe_out, arb_lost} <= 4'b0001;
              end
            end else
              ack_seen <= ~sda_s;
          end else if (scl_fall && skip) begin
            skip <= 1'b0;
          end else if (ack_slot) begin
            bitcnt <= 4'd8;
            if (role_tx)
              sda_oe_out <= 1'b0;
            else if (!is_master && !addressed) begin
              if (kind_addr && (own_hit || gc_hit)) begin
                {sda_oe_out, addressed} <= 2'b11;
                gc_mode <= ~own_hit;
                rw <= shift[0];
              end else begin
                if (arb_lost) begin
                  code <= cd(C_ARB);
                  si_out <= 1'b1;
                end
                st <= SSR_LISTEN;
              end
            end else
              sda_oe_out <= ack_assert;
          end else if (byte_end) begin
            code <= cd(done_code);
            si_out <= 1'b1;
            sda_oe_out <= 1'b0;
            if (!role_tx)
              data_q <= shift;
            if (!is_master && role_tx && !ack_seen) begin
              {addressed, scl_oe_out} <= 2'b00;
              st <= SSR_LISTEN;
            end else begin
              scl_oe_out <= 1'b1;
              st <= SSR_WAIT;
            end
            if (kind_addr) begin
              role_tx <= is_master ? ~rw : rw;
              arb_lost <= 1'b0;
            end
            kind_addr <= 1'b0;
          end else if (scl_fall) begin
            bitcnt <= bitcnt + 4'd1;
            if (role_tx)
              sda_oe_out <= ~shift[7];
          end
        end
        default: st <= SSR_IDLE;
      endcase

      // clock held high too long while the bus is busy
      if (to_hit) begin
        code <= cd(C_TOUT);
        {si_out, err} <= 2'b11;
        {sda_oe_out, scl_oe_out, is_master, addressed} <= 4'h0;
        st <= SSR_WAIT;
      end
    end
  end

  //////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking @(posedge clk_sys_in); endclocking
  default disable iff (sys_rst_in);

  property p_start_code;
    (clk_en_in && st == SSR_START && tmr_hit && !to_hit)
      |=> si_out && code == ($past(rep) ? 5'h02 : 5'h01);
  endproperty
  a_start_code: assert property (p_start_code) else $error("start code wrong");

  property p_addr_w;
    (byte_end && is_master && kind_addr && !rw && ack_seen) |=> code == 5'h03 && si_out;
  endproperty
  a_addr_w: assert property (p_addr_w) else $error("address ack code wrong");

  property p_rx_ack;
    (ack_slot && !role_tx && (is_master || addressed)) |=> sda_oe_out == $past(ack_assert);
  endproperty
  a_rx_ack: assert property (p_rx_ack) else $error("ack drive wrong");

  property p_own_ack;
    (ack_slot && !role_tx && !is_master && !addressed && kind_addr && own_hit)
      |=> sda_oe_out && addressed;
  endproperty
  a_own_ack: assert property (p_own_ack) else $error("own address not acked");

  property p_slv_stop;
    a0_ev |=> code == 5'h14 && si_out;
  endproperty
  a_slv_stop: assert property (p_slv_stop) else $error("slave stop code wrong");

  property p_tout;
    (clk_en_in && to_hit) |=> code == 5'h1a && si_out && !scl_oe_out && st == SSR_WAIT;
  endproperty
  a_tout: assert property (p_tout) else $error("timeout code wrong");

  property p_berr;
    berr_ev |=> code == 5'h00 && si_out && err;
  endproperty
  a_berr: assert property (p_berr) else $error("bus error code wrong");

  property p_idle;
    $rose(si_out) |-> code != 5'h1f;
  endproperty
  a_idle: assert property (p_idle) else $error("flag raised for idle");

  property p_gc_off;
    (ack_slot && !role_tx && !is_master && !addressed && !gc_en && shift == 8'h00
      && own_addr != 7'h00) |=> !addressed ##1 !sda_oe_out;
  endproperty
  a_gc_off: assert property (p_gc_off) else $error("general call taken");

  property p_stat_low;
    (avs_read_in && !avs_waitrequest_out && avs_address_in == 3'h3)
      |-> avs_readdata_out[2:0] == 3'h0;
  endproperty
  a_stat_low: assert property (p_stat_low) else $error("status low bits set");

  property p_sw_stop;
    (clk_en_in && st == SSR_WAIT && si_clr && wd[CTL_STOP] && !is_master)
      |=> st == SSR_IDLE ##1 code == 5'h1f;
  endproperty
  a_sw_stop: assert property (p_sw_stop) else $error("stop did not reset");

endmodule

// >>> ssr_slave_model.sv
// Purpose: behavioural target device on the two-wire bus
// Assumes: open-drain lines, pull asserts a low on the data line
// Notes:   write transfers only; acks its address and every data byte
`timescale 1ns/10ps
module ssr_slave_model #(
  parameter logic [6:0] ADDR = 7'h2a
) (
  input  wire logic scl_in,
  input  wire logic sda_in,
  output logic      pull_out
);
  logic [7:0] sh;
  int         nb;
  logic       act;
  logic       first;
  initial begin
    pull_out = 1'b0;
    act = 1'b0;
    sh = 8'h00;
  end
  always @(negedge sda_in) if (scl_in) begin
    act = 1'b1;
    first = 1'b1;
    nb = 0;
    pull_out = 1'b0;
  end
  always @(posedge sda_in) if (scl_in) begin
    act = 1'b0;
    pull_out = 1'b0;
  end
  always @(posedge scl_in) if (act) begin
    if (nb < 8) sh = {sh[6:0], sda_in};
    nb = nb + 1;
  end
  // ack is changed only while the clock is low, so it never forms a stop
  always @(negedge scl_in) if (act) begin
    if (nb == 8) begin
      pull_out = first ? (sh[7:1] == ADDR) : 1'b1;
    end else if (nb == 9) begin
      pull_out = 1'b0;
      nb = 0;
      first = 1'b0;
    end
  end
endmodule

// >>> smbus_status_code_reporter_tb.sv
// Purpose: self-checking bench for the status reporter
// Assumes: one target at address 0x2a behind pull-ups
// Notes:   rate left at zero so each bit takes twelve clocks (five low, seven high)
`timescale 1ns/10ps
module smbus_status_code_reporter_tb;
  import ssr_pkg::*;
  logic        clk_sys_in = 1'b0;
  logic        sys_rst_in = 1'b1;
  logic [2:0]  adr = 3'h0;
  logic        rd = 1'b0;
  logic        wr = 1'b0;
  logic [31:0] wdat = 32'h0;
  logic [31:0] rdat;
  logic        wait_rq;
  logic        scl_oe, sda_oe, pull, si;
  wire         scl = ~scl_oe;
  wire         sda = ~(sda_oe | pull);
  int          error_cnt = 0;
  int          samples_checked = 0;
  int          cyc = 0;
  logic [7:0]  v;
  always #50 clk_sys_in = ~clk_sys_in;
  ssr_smbus i_dut (.clk_sys_in(clk_sys_in), .sys_rst_in(sys_rst_in), .clk_en_in(1'b1),
    .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdat),
    .avs_byteenable_in(4'hf), .avs_readdata_out(rdat), .avs_waitrequest_out(wait_rq),
    .scl_in(scl), .scl_out(), .scl_oe_out(scl_oe), .sda_in(sda), .sda_out(),
    .sda_oe_out(sda_oe), .si_out(si));
  ssr_slave_model i_slave (.scl_in(scl), .sda_in(sda), .pull_out(pull));
  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    $display("checks %0d errors %0d", samples_checked, error_cnt);
    if (error_cnt == 0 && samples_checked > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  always @(posedge clk_sys_in) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      wrap_up();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      error_cnt++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic [4:0] off, input logic w, input logic [7:0] d);
    @(posedge clk_sys_in);
    adr <= off[4:2];
    wdat <= {24'h0, d};
    wr <= w;
    rd <= ~w;
    do @(posedge clk_sys_in); while (wait_rq !== 1'b0);
    v = rdat[7:0];
    wr <= 1'b0;
    rd <= 1'b0;
  endtask
  task automatic wait_si;
    int n;
    n = 0;
    do begin
      @(posedge clk_sys_in);
      n++;
    end while (si !== 1'b1 && n < 3000);
    if (si !== 1'b1) error_cnt++;
  endtask
  // sends one byte and checks the code that comes back
  task automatic send(input logic [7:0] d, input logic [7:0] code);
    bus(OFF_DATA, 1'b1, d);
    bus(OFF_CTRL, 1'b1, 8'h40);
    wait_si();
    bus(OFF_STATUS, 1'b0, 8'h0); // status is only ever read
    check(v, code);
  endtask
  // stop request, then wait for the bus to fall idle
  task automatic stop_idle;
    int n;
    bus(OFF_CTRL, 1'b1, 8'h42);
    n = 0;
    do begin
      bus(OFF_CTRL, 1'b0, 8'h0);
      n++;
    end while (v[CTL_BUSY] !== 1'b0 && n < 200);
    bus(OFF_STATUS, 1'b0, 8'h0);
    check(v, C_IDLE);
    check({7'h0, si}, 8'h00);
  endtask
  task automatic t_master(input logic [6:0] a, input logic [7:0] acode);
    bus(OFF_CTRL, 1'b1, 8'h44);
    wait_si();
    bus(OFF_STATUS, 1'b0, 8'h0);
    check(v, C_START);
    send({a, 1'b0}, acode);
    if (acode == C_AW_ACK) begin
      send(8'h5a, C_TX_ACK);
      check(i_slave.sh, 8'h5a);
      // stop cleared, start set in one write: repeated start
      bus(OFF_CTRL, 1'b1, 8'h44);
      wait_si();
      bus(OFF_STATUS, 1'b0, 8'h0);
      check(v, C_RSTART);
    end else begin
      // stop and start together: acknowledge poll of the target
      bus(OFF_CTRL, 1'b1, 8'h46);
      wait_si();
      bus(OFF_STATUS, 1'b0, 8'h0);
      check(v, C_START);
    end
    stop_idle();
  endtask
  ////////////////////////////////////////////////////////////////////////////
  initial begin
    repeat (8) @(posedge clk_sys_in);
    sys_rst_in <= 1'b0;
    bus(OFF_STATUS, 1'b0, 8'h0);
    check(v, C_IDLE);
    bus(5'h1c, 1'b0, 8'h0);
    check(v, 8'h00);
    t_master(7'h2a, C_AW_ACK);
    t_master(7'h13, C_AW_NAK);
    wrap_up();
  end
endmodule
